// ===== core/mpdp_port.sv
// Purpose: Device side of the parallel MCU host port of a display module.
// Assumes: Host pins synchronous to MCLK_I; strobes last two clocks.
// Notes:   Side pins other than TOUCH_IRQ_I are static levels passed to the panel logic.
`timescale 1ns/10ps
`default_nettype none
`include "mpdp_map.svh"
module mpdp_port
    import mpdp_pkg::*;
(
    // Clock and reset
    input  wire logic                    MCLK_I,
    input  wire logic                    RST_N_I,
    // Host control, all active low except data/command
    input  wire logic                    CS_N_I,
    input  wire logic                    DC_I,
    input  wire logic                    RD_N_I,
    input  wire logic                    WR_N_I,
    // Data bus, three signals
    input  wire mpdp_pkg::mpdp_word_t    DATA_I,
    output mpdp_pkg::mpdp_word_t         DATA_O,
    output logic                         DATA_OE_O,
    // Core side
    input  wire logic [`MPDP_MODE_W-1:0] MODE_I,
    input  wire mpdp_pkg::mpdp_word_t    RD_DATA_I,
    output logic                         CMD_VLD_O,
    output mpdp_pkg::mpdp_word_t         CMD_O,
    output logic                         PARAM_VLD_O,
    output mpdp_pkg::mpdp_word_t         PARAM_O,
    output logic                         RD_REQ_O,
    output logic                         RD_IS_DATA_O,
    output logic                         PIX_VLD_O,
    output mpdp_pkg::mpdp_pixel_t        PIX_O,
    // Side pins
    input  wire logic                    BACKLIGHT_ON_I,
    input  wire logic                    SCAN_LR_I,
    input  wire logic                    SCAN_UD_I,
    input  wire logic                    TOUCH_RESET_N_I,
    input  wire logic                    TOUCH_WAKE_N_I,
    input  wire logic                    TOUCH_IRQ_I,
    output logic                         BACKLIGHT_LIT_O,
    output logic                         SCAN_L2R_O,
    output logic                         SCAN_B2T_O,
    output logic                         TOUCH_HOLD_O,
    output logic                         TOUCH_WAKE_O,
    output logic                         TOUCH_IRQ_O
);
    import mpdp_pkg::*;

    // A wider bus would need packing rules of its own
    if (`MPDP_BUS_W != 16)
    begin
        $error("mpdp_port serves a 16-bit bus only");
    end

    typedef struct packed {
        mpdp_ctl_t  prev;
        mpdp_wr_t   wr;
        logic       wr_vld;
        logic       rd_req;
        logic       rd_dc;
        logic       oe;
        mpdp_word_t rd_word;
        logic [4:0] side;
    } mpdp_st_t;

    mpdp_st_t st;
    mpdp_st_t next_st;
    logic     wr_rise;
    logic     rd_fall;
    logic     rd_low;

    // ----------------------------------------------------------------
    // Strobe edges
    // ----------------------------------------------------------------
    // Chip select is looked at when the read strobe opens and at the write strobe's rise
    assign wr_rise = !st.prev.wr_n && WR_N_I && !CS_N_I;
    assign rd_fall = st.prev.rd_n && !RD_N_I && !CS_N_I;
    assign rd_low  = !RD_N_I && !CS_N_I;

    always_comb
    begin
        next_st        = st;
        next_st.prev   = '{ CS_N_I, DC_I, RD_N_I, WR_N_I };
        next_st.wr_vld = wr_rise;
        // The bus value of the last clock before the rise is taken,
        // since the host may release it together with the strobe
        if (wr_rise)
            next_st.wr = '{ st.prev.dc, st.wr.word };
        if (!WR_N_I && !CS_N_I)
            next_st.wr.word = DATA_I;
        next_st.rd_req = rd_fall;
        if (rd_fall)
            next_st.rd_dc = DC_I;
        next_st.oe = rd_low;
        if (rd_low)
            next_st.rd_word = RD_DATA_I;
        // Side pins other than TOUCH_IRQ_I are static: registered so they are clean levels
        next_st.side = { BACKLIGHT_ON_I, SCAN_LR_I, SCAN_UD_I,
                         TOUCH_RESET_N_I, TOUCH_WAKE_N_I };
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            st      <= '0;
            st.prev <= '{ 1'b1, 1'b0, 1'b1, 1'b1 };
            // Pull-ups on the backlight enable and SCAN_LR_I: lit, left to right out of reset
            st.side <= 5'h18;
        end
        else
            st <= next_st;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign CMD_VLD_O    = st.wr_vld && !st.wr.is_data;
    assign CMD_O        = st.wr.word;
    assign PARAM_VLD_O  = st.wr_vld && st.wr.is_data;
    assign PARAM_O      = st.wr.word;
    assign RD_REQ_O     = st.rd_req;
    assign RD_IS_DATA_O = st.rd_dc;
    // Upper lines carry the read word too; the host ignores them
    // in narrow modes and never drives them
    assign DATA_O       = st.rd_word;
    assign DATA_OE_O    = st.oe && !RD_N_I && !CS_N_I;

    assign BACKLIGHT_LIT_O = st.side[4];
    assign SCAN_L2R_O      = st.side[3];
    assign SCAN_B2T_O      = st.side[2];
    assign TOUCH_HOLD_O    = !st.side[1];
    assign TOUCH_WAKE_O    = !st.side[0];
    assign TOUCH_IRQ_O     = TOUCH_IRQ_I;

    mpdp_packer u_packer
    (
        .clk_i      (MCLK_I),
        .rst_n_i    (RST_N_I),
        .word_vld_i (st.wr_vld),
        .word_i     (st.wr),
        .mode_i     (MODE_I),
        .pix_vld_o  (PIX_VLD_O),
        .pix_o      (PIX_O)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_wr_rise;
        !WR_N_I && !CS_N_I ##1 WR_N_I && !CS_N_I;
    endsequence

    AST_WR_CAPTURE: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        s_wr_rise |=> (CMD_VLD_O || PARAM_VLD_O))
        else $error("write strobe rise not captured");
    AST_WR_ONLY_ON_RISE: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        (CMD_VLD_O || PARAM_VLD_O) |-> $past(WR_N_I, 1) && !$past(WR_N_I, 2))
        else $error("word captured without strobe rise");
    AST_WR_DATA: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        s_wr_rise |=> (CMD_O == $past(DATA_I, 2)))
        else $error("captured word differs from bus");
    AST_RD_DRIVE: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        (!RD_N_I && !CS_N_I)[*2] |-> DATA_OE_O)
        else $error("bus not driven during read");
    AST_RD_RELEASE: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        RD_N_I |-> !DATA_OE_O)
        else $error("bus driven outside read");
    AST_DC_CMD: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        (!DC_I && !WR_N_I && !CS_N_I ##1 WR_N_I && !CS_N_I) |=> CMD_VLD_O)
        else $error("command word not flagged");
    AST_DC_DATA: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        (DC_I && !WR_N_I && !CS_N_I ##1 WR_N_I && !CS_N_I) |=> PARAM_VLD_O)
        else $error("data word not flagged");
    // The first edge after reset still shows the pull-up pattern, so
    // the level checks start one edge later
    AST_BACKLIGHT: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        $past(RST_N_I) |-> BACKLIGHT_LIT_O == $past(BACKLIGHT_ON_I, 1))
        else $error("backlight does not follow enable");
    AST_TOUCH_RST: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        $past(RST_N_I) |-> TOUCH_HOLD_O == !$past(TOUCH_RESET_N_I, 1))
        else $error("touch reset not followed");
    AST_SCAN: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        $past(RST_N_I) |-> SCAN_B2T_O == $past(SCAN_UD_I, 1))
        else $error("vertical scan not followed");
    AST_SCAN_LR: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        $past(RST_N_I) |-> SCAN_L2R_O == $past(SCAN_LR_I, 1))
        else $error("horizontal scan not followed");
    AST_TOUCH_WAKE: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        $past(RST_N_I) |-> TOUCH_WAKE_O == !$past(TOUCH_WAKE_N_I, 1))
        else $error("touch wake not followed");

    // ----------------------------------------------------------------
    // Read and select checks
    // ----------------------------------------------------------------
    sequence s_rd_fall;
        RD_N_I ##1 !RD_N_I && !CS_N_I;
    endsequence

    AST_RD_REQ: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        s_rd_fall |=> RD_REQ_O && RD_IS_DATA_O == $past(DC_I, 1))
        else $error("read strobe fall not answered");
    AST_RD_DATA: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        DATA_OE_O |-> DATA_O == $past(RD_DATA_I, 1))
        else $error("read word not from previous clock");
    AST_CS_REFUSED: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        $past(CS_N_I) |-> !(CMD_VLD_O || PARAM_VLD_O))
        else $error("word captured with chip select high");
endmodule
`default_nettype wire

// ===== core/mpdp_map.svh
// Purpose: Constants for the parallel display host port.
// Assumes: Included by its bare name.
// Notes:   Bus-width mode codes and pixel cycle counts.
`ifndef MPDP_MAP_SVH
`define MPDP_MAP_SVH
`define MPDP_BUS_W        16
`define MPDP_MODE_W       3
`define MPDP_MODE_16_565  3'h0
`define MPDP_MODE_16_888  3'h1
`define MPDP_MODE_12      3'h2
`define MPDP_MODE_9       3'h3
`define MPDP_MODE_8       3'h4
`define MPDP_CYC_565      2'h1
`define MPDP_CYC_888      2'h3
`define MPDP_CYC_12       2'h2
`define MPDP_CYC_9        2'h2
`define MPDP_CYC_8        2'h3
`endif

// ===== core/mpdp_pkg.sv
// Purpose: Types for the parallel display host port.
// Assumes: mpdp_map.svh holds the numbers.
// Notes:   Pixel is 8-8-8; narrow formats are left aligned.
`include "mpdp_map.svh"
package mpdp_pkg;
    typedef logic [`MPDP_BUS_W-1:0] mpdp_word_t;
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } mpdp_pixel_t;
    typedef struct packed {
        logic       is_data;
        mpdp_word_t word;
    } mpdp_wr_t;
    typedef struct packed {
        logic cs_n;
        logic dc;
        logic rd_n;
        logic wr_n;
    } mpdp_ctl_t;
endpackage

// ===== core/mpdp_packer.sv
// Purpose: Gathers data words into pixels per bus-width mode.
// Assumes: One word_vld pulse per written data word.
// Notes:   A command restarts the pixel phase.
`timescale 1ns/10ps
`default_nettype none
`include "mpdp_map.svh"
module mpdp_packer
    import mpdp_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // Words in
    input  wire logic                    word_vld_i,
    input  wire mpdp_pkg::mpdp_wr_t      word_i,
    input  wire logic [`MPDP_MODE_W-1:0] mode_i,
    // Pixels out
    output logic                         pix_vld_o,
    output mpdp_pkg::mpdp_pixel_t        pix_o
);
    import mpdp_pkg::*;

    typedef struct packed {
        logic [1:0]  phase;
        logic        odd;
        mpdp_pixel_t acc;
        mpdp_pixel_t pix;
        logic        vld;
        logic [7:0]  carry;
    } mpdp_pk_st_t;

    mpdp_pk_st_t st;
    mpdp_pk_st_t next_st;

    function automatic logic [1:0] cycles(input logic [2:0] m);
        unique case (m)
            `MPDP_MODE_16_565: cycles = `MPDP_CYC_565;
            `MPDP_MODE_16_888: cycles = `MPDP_CYC_888;
            `MPDP_MODE_12:     cycles = `MPDP_CYC_12;
            `MPDP_MODE_9:      cycles = `MPDP_CYC_9;
            default:           cycles = `MPDP_CYC_8;
        endcase
    endfunction

    always_comb
    begin
        logic [15:0] w;
        logic        last;
        w       = word_i.word;
        next_st = st;
        last    = 1'b0;
        next_st.vld = 1'b0;
        if (word_vld_i && !word_i.is_data)
        begin
            next_st.phase = 2'h0;
            next_st.odd   = 1'b0;
        end
        else if (word_vld_i)
        begin
            last = (st.phase == cycles(mode_i) - 2'h1);
            unique case (mode_i)
                `MPDP_MODE_16_565:
                    next_st.pix = '{ {w[15:11], 3'h0}, {w[10:5], 2'h0},
                                     {w[4:0], 3'h0} };
                `MPDP_MODE_16_888:
                begin
                    // Two pixels over three words, alternating halves
                    if (!st.odd)
                    begin
                        if (st.phase == 2'h0)
                            next_st.acc = '{ w[15:8], w[7:0], 8'h0 };
                        else if (st.phase == 2'h1)
                        begin
                            next_st.pix = '{ st.acc.red, st.acc.green,
                                             w[15:8] };
                            next_st.carry = w[7:0];
                            last = 1'b1;
                        end
                    end
                    else if (st.phase == 2'h0)
                    begin
                        next_st.pix = '{ st.carry, w[15:8], w[7:0] };
                        last = 1'b1;
                    end
                end
                `MPDP_MODE_12:
                    if (st.phase == 2'h0)
                        next_st.acc = '{ w[11:4], {w[3:0], 4'h0}, 8'h0 };
                    else
                        next_st.pix = '{ st.acc.red,
                                         {st.acc.green[7:4], w[11:8]},
                                         w[7:0] };
                `MPDP_MODE_9:
                    if (st.phase == 2'h0)
                        next_st.acc = '{ {w[8:3], 2'h0}, {w[2:0], 5'h0},
                                         8'h0 };
                    else
                        next_st.pix = '{ st.acc.red,
                                         {st.acc.green[7:5], w[8:6], 2'h0},
                                         {w[5:0], 2'h0} };
                default:
                    unique case (st.phase)
                        2'h0:    next_st.acc.red   = w[7:0];
                        2'h1:    next_st.acc.green = w[7:0];
                        default: next_st.pix = '{ st.acc.red,
                                                  st.acc.green, w[7:0] };
                    endcase
            endcase
            if (last)
            begin
                next_st.vld   = 1'b1;
                next_st.phase = 2'h0;
                if (mode_i == `MPDP_MODE_16_888)
                    next_st.odd = ~st.odd;
            end
            else
                next_st.phase = st.phase + 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign pix_vld_o = st.vld;
    assign pix_o     = st.pix;
endmodule
`default_nettype wire

// ===== bench/mpdp_host_model.sv
// Purpose: Behavioural host that works the parallel port pins.
// Assumes: Pins change just after a rising clock edge.
// Notes:   A released bus shows the inverse of the last word.
`timescale 1ns/10ps
`default_nettype none
module mpdp_host_model
(
    // Clock
    input  wire logic                 clk_i,
    // Host pins
    output var  mpdp_pkg::mpdp_ctl_t  ctl_o,
    output wire mpdp_pkg::mpdp_word_t bus_o,
    // Device drive
    input  wire mpdp_pkg::mpdp_word_t dev_data_i,
    input  wire logic                 dev_oe_i
);
    import mpdp_pkg::*;
    mpdp_word_t drv;
    logic       drv_en;

    // Released lines must never look like the last word
    assign bus_o = dev_oe_i ? dev_data_i : (drv_en ? drv : ~drv);
    initial
    begin
        ctl_o  = 4'hf;
        drv    = 16'h0000;
        drv_en = 1'b0;
    end

    // ----------------------------------------------------------------
    // Write: strobe low two clocks, word held until the rise is seen
    // ----------------------------------------------------------------
    task automatic wr(input logic cs_n, input logic dc, input mpdp_word_t w);
        @(posedge clk_i);
        ctl_o.cs_n <= cs_n;
        ctl_o.dc   <= dc;
        ctl_o.wr_n <= 1'b0;
        drv        <= w;
        drv_en     <= 1'b1;
        repeat (2) @(posedge clk_i);
        ctl_o.wr_n <= 1'b1;
        @(posedge clk_i);
        ctl_o.cs_n <= 1'b1;
        drv_en     <= 1'b0;
        @(posedge clk_i);
    endtask

    // ----------------------------------------------------------------
    // Read: strobe low until the device drives, word taken, then rise
    // ----------------------------------------------------------------
    task automatic rd(input logic dc, output mpdp_word_t w, output logic ok);
        @(posedge clk_i);
        ctl_o.cs_n <= 1'b0;
        ctl_o.dc   <= dc;
        ctl_o.rd_n <= 1'b0;
        ok = 1'b0;
        w = 16'h0000;
        // Word is taken at the edge at which the drive is first seen
        for (int i = 0; i < 8 && ok !== 1'b1; i++)
        begin
            @(posedge clk_i);
            ok = dev_oe_i;
            w = bus_o;
        end
        ctl_o.rd_n <= 1'b1;
        ctl_o.cs_n <= 1'b1;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ===== bench/mpdp_port_tb_top.sv
// Purpose: Self-checking bench for the parallel display host port.
// Assumes: The host model owns the strobes and the bus.
// Notes:   Every output pulse must match a queued expectation.
`timescale 1ns/10ps
`default_nettype none
`include "mpdp_map.svh"
module mpdp_port_tb_top;
    import mpdp_pkg::*;
    localparam int NW [5] = '{2, 3, 4, 4, 6};
    localparam logic [2:0] MD [5] = '{`MPDP_MODE_16_565, `MPDP_MODE_16_888,
        `MPDP_MODE_12, `MPDP_MODE_9, `MPDP_MODE_8};
    logic                    clk;
    logic                    rst_n;
    mpdp_ctl_t               ctl;
    mpdp_word_t              bus;
    mpdp_word_t              dout;
    mpdp_word_t              cmd;
    mpdp_word_t              prm;
    mpdp_word_t              rdd;
    mpdp_word_t              got;
    mpdp_pixel_t             pix;
    logic                    oe;
    logic                    cmd_v;
    logic                    prm_v;
    logic                    rdq;
    logic                    rdi;
    logic                    pix_v;
    logic                    ok;
    logic [`MPDP_MODE_W-1:0] mode;
    logic [5:0]              side;
    wire logic [5:0]         sout;
    logic [25:0]             exp_q [$];
    int                      failures;
    int                      samples_checked;

    mpdp_port dut (.MCLK_I(clk), .RST_N_I(rst_n), .CS_N_I(ctl.cs_n),
        .DC_I(ctl.dc), .RD_N_I(ctl.rd_n), .WR_N_I(ctl.wr_n), .DATA_I(bus),
        .DATA_O(dout), .DATA_OE_O(oe), .MODE_I(mode), .RD_DATA_I(rdd),
        .CMD_VLD_O(cmd_v), .CMD_O(cmd), .PARAM_VLD_O(prm_v), .PARAM_O(prm),
        .RD_REQ_O(rdq), .RD_IS_DATA_O(rdi), .PIX_VLD_O(pix_v), .PIX_O(pix),
        .BACKLIGHT_ON_I(side[0]), .SCAN_LR_I(side[1]), .SCAN_UD_I(side[2]),
        .TOUCH_RESET_N_I(side[3]), .TOUCH_WAKE_N_I(side[4]),
        .TOUCH_IRQ_I(side[5]), .BACKLIGHT_LIT_O(sout[0]),
        .SCAN_L2R_O(sout[1]), .SCAN_B2T_O(sout[2]), .TOUCH_HOLD_O(sout[3]),
        .TOUCH_WAKE_O(sout[4]), .TOUCH_IRQ_O(sout[5]));
    mpdp_host_model host (.clk_i(clk), .ctl_o(ctl), .bus_o(bus),
        .dev_data_i(dout), .dev_oe_i(oe));

    task automatic check(input logic [25:0] seen, input logic [25:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic end_of_test();
        $display("checked %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Narrow formats come out left aligned with zero fill
    function automatic mpdp_pixel_t exp_pix(input logic [2:0] m,
        input mpdp_word_t a, input mpdp_word_t b, input mpdp_word_t c,
        input logic second);
        case (m)
            `MPDP_MODE_16_565: exp_pix = {a[15:11], 3'h0, a[10:5], 2'h0,
                a[4:0], 3'h0};
            `MPDP_MODE_16_888: exp_pix = second ? {b[7:0], c} : {a, b[15:8]};
            `MPDP_MODE_12: exp_pix = {a[11:4], a[3:0], b[11:8], b[7:0]};
            `MPDP_MODE_9: exp_pix = {a[8:3], 2'h0, a[2:0], b[8:6], 2'h0,
                b[5:0], 2'h0};
            default: exp_pix = {a[7:0], b[7:0], c[7:0]};
        endcase
    endfunction

    task automatic see(input logic [25:0] v);
        if (exp_q.size() == 0)
            check(v, ~v);
        else
            check(v, exp_q.pop_front());
    endtask

    always @(posedge clk)
    begin
        if (cmd_v === 1'b1) see({2'h0, 8'h00, cmd});
        if (prm_v === 1'b1) see({2'h1, 8'h00, prm});
        if (rdq === 1'b1) see({2'h3, 23'h0, rdi});
        if (pix_v === 1'b1) see({2'h2, pix});
    end

    // Upper lines in narrow modes carry junk, as if left floating
    task automatic run_mode(input int k, input logic pre);
        mpdp_word_t w [6];
        mpdp_word_t c;
        logic [2:0] m;
        m = MD[k];
        @(posedge clk);
        mode <= m;
        if (pre)
        begin
            c = 16'($urandom);
            exp_q.push_back({2'h1, 8'h00, c});
            host.wr(1'b0, 1'b1, c);
        end
        c = 16'($urandom);
        exp_q.push_back({2'h0, 8'h00, c});
        host.wr(1'b0, 1'b0, c);
        for (int i = 0; i < NW[k]; i++)
        begin
            w[i] = 16'($urandom);
            exp_q.push_back({2'h1, 8'h00, w[i]});
            if (m == `MPDP_MODE_16_565)
                exp_q.push_back({2'h2, exp_pix(m, w[i], w[i], w[i], 1'b0)});
            else if (m == `MPDP_MODE_16_888 && i > 0)
                exp_q.push_back({2'h2, exp_pix(m, w[0], w[1], w[2], i == 2)});
            else if (m != `MPDP_MODE_8 && m != `MPDP_MODE_16_888 && i % 2)
                exp_q.push_back({2'h2, exp_pix(m, w[i-1], w[i], w[i], 1'b0)});
            else if (m == `MPDP_MODE_8 && i % 3 == 2)
                exp_q.push_back({2'h2,
                    exp_pix(m, w[i-2], w[i-1], w[i], 1'b0)});
            host.wr(1'b0, 1'b1, w[i]);
        end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        failures = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        mode = `MPDP_MODE_16_565;
        rdd = 16'h0000;
        side = 6'h00;
        void'($urandom(32'hc7b9));
        repeat (3) @(posedge clk);
        #1 check(sout, 6'h1b);
        check(oe, 1'b0);
        @(posedge clk);
        @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            // First four passes walk every scan-select pair
            if (i < 4)
                side <= {3'($urandom % 8), i[1:0], 1'b0};
            else
                side <= 6'($urandom);
            repeat (2) @(posedge clk);
            #1 check(sout, {side[5], ~side[4:3], side[2:0]});
        end
        host.wr(1'b1, 1'b0, 16'h00ff);
        for (int k = 0; k < 5; k++)
            run_mode(k, k == 4);
        for (int d = 0; d < 2; d++)
        begin
            @(posedge clk);
            rdd <= 16'($urandom);
            exp_q.push_back({2'h3, 23'h0, d[0]});
            host.rd(d[0], got, ok);
            check(ok, 1'b1);
            if (ok !== 1'b1)
                break;
            check(got, rdd);
            #1 check(oe, 1'b0);
        end
        repeat (4) @(posedge clk);
        check(26'(exp_q.size()), 26'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
